// ---- inc/sd_adc_defines.svh ----
// offsets, field positions, reset values and counts of the converter control block
`ifndef SD_ADC_DEFINES_SVH
`define SD_ADC_DEFINES_SVH
`define ADDR_CTL0 4'h0
`define ADDR_CTL1 4'h1
`define ADDR_CLKSEL 4'h2
`define ADDR_RES_LO 4'h3
`define ADDR_RES_MID 4'h4
`define ADDR_RES_HI 4'h5
`define ADDR_IRQ 4'h6
`define CTL0_FRST 7
`define CTL0_SLEEP 6
`define CTL0_OFF 5
`define CTL0_RATE_LSB 2
`define CTL0_REF 0
`define CTL1_MODE_LSB 5
`define CTL1_BUFN 4
`define CTL1_BUFP 3
`define CTL1_LATCH 2
`define CTL1_EOC 1
`define IRQ_GIE 0
`define IRQ_CIE 1
`define IRQ_FLAG 2
`define CTL0_RESET 8'h20
`define CTL0_MASK 8'hFD
`define CTL1_MASK 8'hFE
`define CLKSEL_MASK 8'h1F
`define CLK_UNDIV 5'h1F
`define OSR_MAX 16384
`define DIV_LONG 30
`define DIV_SHORT 12
`endif

// ---- inc/sd_adc_pkg.sv ----
// types of the converter control block
package sd_adc_pkg;
    typedef enum logic [1:0] {
        POWER_DOWN,
        ASLEEP,
        FILTER_RESET,
        CONVERTING
    } mode_t;
endpackage

// ---- rtl/clock_divider.sv ----
// converter clock enable generated from the system clock
`timescale 1ns/10ps
`include "sd_adc_defines.svh"
module clock_divider (
    input wire logic clock,
    input wire logic rst,
    input wire logic [4:0] divSel,
    output logic tick
);
    typedef struct packed {
        logic [5:0] cnt;
        logic tick;
    } div_state_t;
    div_state_t s_q, s_d;
    logic [5:0] limit;
    always_comb begin
        s_d = s_q;
        // two system cycles per step, times field plus one
        limit = 6'({divSel, 1'b1});
        s_d.tick = 1'b0;
        if (divSel == `CLK_UNDIV) begin // [RULE_15]
            s_d.cnt = 6'h00;
            s_d.tick = 1'b1;
        end else if (s_q.cnt >= limit) begin // [RULE_15]
            s_d.cnt = 6'h00;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 6'h01;
        end
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign tick = s_q.tick;
    a_fast_tick: assert property (@(posedge clock) disable iff (rst) // [RULE_15]
        (divSel == `CLK_UNDIV) && ($past(divSel) == `CLK_UNDIV) |=> tick)
        else $error("undivided clock did not tick every cycle");
    a_div_spacing: assert property (@(posedge clock) disable iff (rst) // [RULE_15]
        (divSel == 5'h00) && $stable(divSel) && tick |=> !tick)
        else $error("divide by two ticked twice in a row");
endmodule

// ---- rtl/conversion_timer.sv ----
// counts converter clocks to the end of each conversion
`timescale 1ns/10ps
`include "sd_adc_defines.svh"
module conversion_timer #(
    parameter int CNT_W = 20
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic run,
    input wire logic tick,
    input wire logic [CNT_W-1:0] period,
    output logic done
);
    if (CNT_W < 20) begin
        $error("counter too narrow for longest conversion");
    end
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic done;
    } tmr_state_t;
    tmr_state_t s_q, s_d;
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (!run) begin // [RULE_21]
            s_d.cnt = '0;
        end else if (tick) begin
            if (s_q.cnt >= period - 1'b1) begin // [RULE_09]
                s_d.cnt = '0;
                s_d.done = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 1'b1;
            end
        end
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign done = s_q.done;
    a_idle_quiet: assert property (@(posedge clock) disable iff (rst) // [RULE_21]
        !run |=> !done)
        else $error("conversion finished while stopped");
endmodule

// ---- rtl/sigma_delta_adc_control.sv ----
// control, status and result registers of the delta-sigma converter
// Operation
// (RULE_01) pulsing filter reset high then low restarts filter and conversion sequence
// (RULE_02) sleep with power on keeps amplifier on, converter stopped
// (RULE_03) power-off, reset value one, shuts amplifier and converter regardless
// (RULE_04) filter reset high while powered holds the decimation filter in reset
// (RULE_05) normal mode: chopper two, oversampling 16384 halving down to 128
// (RULE_06) low-latency mode: same oversampling ratios, chopper one
// (RULE_07) reference select: zero internal, one external reference pins
// (RULE_08) filter mode field: divide by 30 or 12, normal or low latency
// (RULE_09) one result per divider times chopper times oversampling converter clocks
// (RULE_10) latch set holds current result, later results not stored
// (RULE_11) while latched no interrupt request and end flag unchanged
// (RULE_12) software sets latch before reading three bytes, clears after
// (RULE_13) end flag set on completion, cleared only by software write
// (RULE_14) completion sets interrupt flag, interrupt when both enables set
// (RULE_15) clock field divides system clock by two times field plus one, 11111 undivided
// (RULE_16) software programs clock field for a 4.8MHz converter clock
// (RULE_17) latch off: every new result overwrites the data registers
// (RULE_18) software clears power-off and sleep, then pulses filter reset
// (RULE_19) result is 20-bit two's complement, sign in top bit
// (RULE_20) unimplemented control register bits read as zero
// (RULE_21) no results and no counting while reset, asleep or powered off
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/10ps
`include "sd_adc_defines.svh"
module sigma_delta_adc_control #(
    parameter int RES_W = 20
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [3:0] addr,
    input wire logic [7:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    output logic [7:0] rdData,
    input wire logic [RES_W-1:0] filterResult,
    output logic filterResetHold,
    output logic amplifierPowerEn,
    output logic converterRunEn,
    output logic refExternal,
    output logic refBufNegEn,
    output logic refBufPosEn,
    output logic chopperTwo,
    output logic [2:0] outputRateSel,
    output logic lowLatency,
    output logic converterClockTick,
    output logic resultReady,
    output logic [RES_W-1:0] resultOut,
    output logic irqOut
);
    // the result byte map below is fixed at 20 bits
    if (RES_W != 20) begin
        $error("result width must be 20 bits");
    end

    typedef struct packed {
        logic [7:0] ctl0;
        logic [7:0] ctl1;
        logic [4:0] clkDiv;
        logic globalIrqEn;
        logic convIrqEn;
        logic irqFlag;
        logic [RES_W-1:0] result;
        logic [7:0] rd;
        logic ready;
    } ctl_state_t;
    ctl_state_t s_q, s_d;

    logic tick;
    logic done;
    logic run;
    logic [19:0] period;
    sd_adc_pkg::mode_t mode;

    // oversampling ratio from the rate field
    function automatic logic [14:0] osr_of(input logic [2:0] code);
        osr_of = 15'(`OSR_MAX >> code);
    endfunction

    // [RULE_03] [RULE_02] [RULE_04]
    always_comb begin
        if (s_q.ctl0[`CTL0_OFF]) begin
            mode = sd_adc_pkg::POWER_DOWN;
        end else if (s_q.ctl0[`CTL0_SLEEP]) begin
            mode = sd_adc_pkg::ASLEEP;
        end else if (s_q.ctl0[`CTL0_FRST]) begin
            mode = sd_adc_pkg::FILTER_RESET;
        end else begin
            mode = sd_adc_pkg::CONVERTING;
        end
    end

    logic modeLow;
    logic divShort;
    logic [4:0] divVal;
    logic [19:0] osrVal;
    assign modeLow = s_q.ctl1[`CTL1_MODE_LSB+2]; // [RULE_08]
    assign divShort = s_q.ctl1[`CTL1_MODE_LSB+1]; // [RULE_08]
    assign divVal = divShort ? 5'(`DIV_SHORT) : 5'(`DIV_LONG);
    assign osrVal = 20'(osr_of(s_q.ctl0[`CTL0_RATE_LSB+:3]));
    // [RULE_05] [RULE_06] [RULE_09]
    assign period = 20'(divVal * osrVal) << (modeLow ? 1'b0 : 1'b1);
    assign run = (mode == sd_adc_pkg::CONVERTING); // [RULE_21]

    clock_divider u_div (
        .clock(clock),
        .rst(rst),
        .divSel(s_q.clkDiv),
        .tick(tick)
    );

    // a fresh sequence starts from zero whenever the filter leaves reset
    conversion_timer #(.CNT_W(20)) u_tmr (
        .clock(clock),
        .rst(rst),
        .run(run), // [RULE_01]
        .tick(tick),
        .period(period),
        .done(done)
    );

    logic latched;
    logic wrCtl1;
    logic wrIrq;
    assign latched = s_q.ctl1[`CTL1_LATCH];
    assign wrCtl1 = wrStrobe && (addr == `ADDR_CTL1);
    assign wrIrq = wrStrobe && (addr == `ADDR_IRQ);

    always_comb begin
        s_d = s_q;
        s_d.ready = 1'b0;
        s_d.rd = 8'h00;
        if (wrStrobe) begin
            if (addr == `ADDR_CTL0) begin
                s_d.ctl0 = wrData & `CTL0_MASK; // [RULE_20]
            end else if (addr == `ADDR_CTL1) begin
                s_d.ctl1 = wrData & `CTL1_MASK; // [RULE_20]
            end else if (addr == `ADDR_CLKSEL) begin
                s_d.clkDiv = wrData[4:0];
            end else if (addr == `ADDR_IRQ) begin
                s_d.globalIrqEn = wrData[`IRQ_GIE];
                s_d.convIrqEn = wrData[`IRQ_CIE];
                s_d.irqFlag = wrData[`IRQ_FLAG];
            end
        end
        if (done && !latched) begin // [RULE_10] [RULE_11]
            s_d.result = filterResult; // [RULE_17] [RULE_19]
            s_d.ready = 1'b1;
            // set wins over a clearing write in the same cycle
            s_d.ctl1[`CTL1_EOC] = 1'b1; // [RULE_13]
            s_d.irqFlag = 1'b1; // [RULE_14]
        end
        if (rdStrobe) begin
            if (addr == `ADDR_CTL0) begin
                s_d.rd = s_q.ctl0;
            end else if (addr == `ADDR_CTL1) begin
                s_d.rd = s_q.ctl1;
            end else if (addr == `ADDR_CLKSEL) begin
                s_d.rd = {3'b000, s_q.clkDiv};
            end else if (addr == `ADDR_RES_LO) begin
                s_d.rd = s_q.result[7:0];
            end else if (addr == `ADDR_RES_MID) begin
                s_d.rd = s_q.result[15:8];
            end else if (addr == `ADDR_RES_HI) begin
                s_d.rd = {4'h0, s_q.result[19:16]};
            end else if (addr == `ADDR_IRQ) begin
                s_d.rd = {5'h00, s_q.irqFlag, s_q.convIrqEn, s_q.globalIrqEn};
            end else begin
                s_d.rd = 8'h00;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s_q <= '0;
            s_q.ctl0 <= `CTL0_RESET; // [RULE_03]
        end else begin
            s_q <= s_d;
        end
    end

    assign rdData = s_q.rd;
    assign filterResetHold = (mode != sd_adc_pkg::CONVERTING); // [RULE_04]
    assign amplifierPowerEn = (mode != sd_adc_pkg::POWER_DOWN); // [RULE_03]
    assign converterRunEn = (mode == sd_adc_pkg::FILTER_RESET) || run; // [RULE_02]
    assign refExternal = s_q.ctl0[`CTL0_REF]; // [RULE_07]
    assign refBufNegEn = s_q.ctl1[`CTL1_BUFN];
    assign refBufPosEn = s_q.ctl1[`CTL1_BUFP];
    assign chopperTwo = !modeLow; // [RULE_05] [RULE_06]
    assign outputRateSel = s_q.ctl0[`CTL0_RATE_LSB+:3];
    assign lowLatency = modeLow;
    assign converterClockTick = tick;
    assign resultReady = s_q.ready;
    assign resultOut = s_q.result;
    assign irqOut = s_q.irqFlag && s_q.globalIrqEn && s_q.convIrqEn; // [RULE_14]

    sequence doneFree;
        done && !latched;
    endsequence

    sequence writeOf(logic [3:0] a);
        wrStrobe && addr == a;
    endsequence

    sequence readOf(logic [3:0] a);
        rdStrobe && addr == a;
    endsequence

    // a filter leaving reset: counting starts over from zero
    sequence restart;
        !run ##1 run;
    endsequence

    a_result_store: assert property (@(posedge clock) disable iff (rst) // [RULE_17]
        doneFree |=> resultOut == $past(filterResult) && s_q.ctl1[`CTL1_EOC])
        else $error("completed result not stored");

    a_latch_hold: assert property (@(posedge clock) disable iff (rst) // [RULE_10]
        latched |=> $stable(resultOut))
        else $error("latched result changed");

    a_latch_noflag: assert property (@(posedge clock) disable iff (rst) // [RULE_11]
        latched && !wrIrq && !s_q.irqFlag |=> !s_q.irqFlag)
        else $error("interrupt raised while latched");

    a_eoc_sticky: assert property (@(posedge clock) disable iff (rst) // [RULE_13]
        s_q.ctl1[`CTL1_EOC] && !wrCtl1 |=> s_q.ctl1[`CTL1_EOC])
        else $error("end flag dropped without a write");

    a_power_down: assert property (@(posedge clock) disable iff (rst) // [RULE_03]
        s_q.ctl0[`CTL0_OFF] |-> !amplifierPowerEn && !converterRunEn)
        else $error("power-off did not shut down");

    a_sleep_mode: assert property (@(posedge clock) disable iff (rst) // [RULE_02]
        !s_q.ctl0[`CTL0_OFF] && s_q.ctl0[`CTL0_SLEEP] |-> amplifierPowerEn && !converterRunEn)
        else $error("sleep mode wrong");

    a_reset_hold: assert property (@(posedge clock) disable iff (rst) // [RULE_04]
        mode == sd_adc_pkg::FILTER_RESET |-> filterResetHold && converterRunEn ##1 !done)
        else $error("filter reset not held");

    a_irq_gate: assert property (@(posedge clock) disable iff (rst) // [RULE_14]
        doneFree and (s_q.globalIrqEn && s_q.convIrqEn && !wrIrq) |=> irqOut)
        else $error("completion with both enables raised no interrupt");

    a_ctl_zero: assert property (@(posedge clock) disable iff (rst) // [RULE_20]
        $past(rdStrobe) && $past(addr) == `ADDR_CTL0 |-> rdData[1] == 1'b0)
        else $error("unimplemented bit read nonzero");

    a_period_min: assert property (@(posedge clock) disable iff (rst) // [RULE_09]
        period >= 20'h0_0600)
        else $error("conversion period too short");

    a_period_max: assert property (@(posedge clock) disable iff (rst) // [RULE_09]
        period <= 20'hF_0000)
        else $error("conversion period too long");

    a_ready_store: assert property (@(posedge clock) disable iff (rst) // [RULE_14]
        doneFree |=> resultReady && s_q.irqFlag)
        else $error("completed result not flagged");

    a_ready_pulse: assert property (@(posedge clock) disable iff (rst) // [RULE_09]
        resultReady |=> !resultReady)
        else $error("result pulse longer than one cycle");

    a_latch_quiet: assert property (@(posedge clock) disable iff (rst) // [RULE_10]
        latched |=> !resultReady)
        else $error("result stored while latched");

    a_result_keep: assert property (@(posedge clock) disable iff (rst) // [RULE_10]
        !(done && !latched) |=> $stable(resultOut))
        else $error("result changed without a completion");

    a_latch_eoc: assert property (@(posedge clock) disable iff (rst) // [RULE_11]
        latched && !wrCtl1 |=> $stable(s_q.ctl1))
        else $error("control 1 changed while latched");

    a_flag_sticky: assert property (@(posedge clock) disable iff (rst) // [RULE_14]
        s_q.irqFlag && !wrIrq |=> s_q.irqFlag)
        else $error("interrupt flag dropped without a write");

    a_restart_clean: assert property (@(posedge clock) disable iff (rst) // [RULE_01]
        restart |=> (!done) [*8])
        else $error("result too soon after a restart");

    a_stopped_idle: assert property (@(posedge clock) disable iff (rst) // [RULE_21]
        !run |-> ##2 !resultReady)
        else $error("result produced while stopped");

    a_amp_on: assert property (@(posedge clock) disable iff (rst) // [RULE_02]
        !s_q.ctl0[`CTL0_OFF] |-> amplifierPowerEn)
        else $error("amplifier off while powered");

    // register bus: writes land next cycle, reads answer next cycle only
    a_ctl0_write: assert property (@(posedge clock) disable iff (rst) // [RULE_20]
        writeOf(`ADDR_CTL0) |=> s_q.ctl0 == ($past(wrData) & `CTL0_MASK))
        else $error("control 0 write not stored");

    a_ctl0_keep: assert property (@(posedge clock) disable iff (rst)
        !(wrStrobe && addr == `ADDR_CTL0) |=> $stable(s_q.ctl0))
        else $error("control 0 changed without a write");

    a_ctl1_write: assert property (@(posedge clock) disable iff (rst) // [RULE_20]
        wrCtl1 && !(done && !latched) |=> s_q.ctl1 == ($past(wrData) & `CTL1_MASK))
        else $error("control 1 write not stored");

    a_clk_write: assert property (@(posedge clock) disable iff (rst) // [RULE_15]
        writeOf(`ADDR_CLKSEL) |=> {3'b000, s_q.clkDiv} == ($past(wrData) & `CLKSEL_MASK))
        else $error("clock field write not stored");

    a_clk_keep: assert property (@(posedge clock) disable iff (rst) // [RULE_15]
        !(wrStrobe && addr == `ADDR_CLKSEL) |=> $stable(s_q.clkDiv))
        else $error("clock field changed without a write");

    a_unused_zero: assert property (@(posedge clock) disable iff (rst) // [RULE_20]
        !s_q.ctl0[1] && !s_q.ctl1[0])
        else $error("unimplemented control bit stored");

    a_ctl1_read: assert property (@(posedge clock) disable iff (rst) // [RULE_20]
        readOf(`ADDR_CTL1) |=> !rdData[0])
        else $error("control 1 spare bit read nonzero");

    a_clk_read: assert property (@(posedge clock) disable iff (rst) // [RULE_20]
        readOf(`ADDR_CLKSEL) |=> rdData[7:5] == 3'b000)
        else $error("clock field spare bits read nonzero");

    a_high_read: assert property (@(posedge clock) disable iff (rst) // [RULE_19]
        readOf(`ADDR_RES_HI) |=> rdData[7:4] == 4'h0)
        else $error("result high byte spare bits nonzero");

    a_irq_read: assert property (@(posedge clock) disable iff (rst) // [RULE_14]
        readOf(`ADDR_IRQ) |=> rdData[7:3] == 5'h00)
        else $error("interrupt register spare bits nonzero");

    a_gap_read: assert property (@(posedge clock) disable iff (rst)
        rdStrobe && addr > `ADDR_IRQ |=> rdData == 8'h00)
        else $error("unmapped address read nonzero");

    a_read_quiet: assert property (@(posedge clock) disable iff (rst)
        !rdStrobe |=> rdData == 8'h00)
        else $error("read data shown without a read");
endmodule

// ---- dv/filter_model.sv ----
// behavioural decimation filter output facing the control block
`timescale 1ns/10ps
module filter_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic filterResetHold,
    output logic [19:0] filterResult
);
    logic [19:0] value_q = 20'h8_0000;
    always_ff @(posedge clock) begin
        if (rst || filterResetHold) begin
            // held filter has no value worth keeping, so keep it moving
            value_q <= ~value_q;
        end else begin
            // odd step sweeps through both signs of the 20-bit range
            value_q <= value_q + 20'h3_1A2B;
        end
    end
    assign filterResult = value_q;
endmodule

// ---- dv/sigma_delta_adc_control_bench.sv ----
// self-checking bench of the converter control block
`timescale 1ns/10ps
`include "sd_adc_defines.svh"
module sigma_delta_adc_control_bench;
    logic clock = 0;
    logic rst = 1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wrData = 8'h00;
    logic wrStrobe = 0;
    logic rdStrobe = 0;
    logic [7:0] rdData;
    logic [19:0] filterResult, resultOut, expRes, held;
    logic filterResetHold, amplifierPowerEn, converterRunEn, refExternal, refBufNegEn;
    logic refBufPosEn, chopperTwo, lowLatency, converterClockTick, resultReady, irqOut;
    logic [2:0] outputRateSel;
    logic [31:0] seed = 32'h0000_005D;
    logic [7:0] c0, c1;
    int numErrors = 0;
    int checked = 0;
    int n, hits;
    int periods[4] = '{3072, 1536, 7680, 3840};
    logic [7:0] modes[4] = '{8'h40, 8'hC0, 8'h00, 8'h80};
    always #20 clock = ~clock;
    sigma_delta_adc_control dut (.clock(clock), .rst(rst), .addr(addr), .wrData(wrData),
        .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .filterResult(filterResult),
        .filterResetHold(filterResetHold), .amplifierPowerEn(amplifierPowerEn),
        .converterRunEn(converterRunEn), .refExternal(refExternal), .refBufNegEn(refBufNegEn),
        .refBufPosEn(refBufPosEn), .chopperTwo(chopperTwo), .outputRateSel(outputRateSel),
        .lowLatency(lowLatency), .converterClockTick(converterClockTick),
        .resultReady(resultReady), .resultOut(resultOut), .irqOut(irqOut));
    filter_model partner (.clock(clock), .rst(rst), .filterResetHold(filterResetHold),
        .filterResult(filterResult));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    // period in converter clocks, from the rate field and the filter mode field
    function automatic int expPeriod(input logic [7:0] c0, input logic [7:0] c1);
        int osr;
        osr = 16384 >> c0[4:2];
        return (c1[6] ? 12 : 30) * (c1[7] ? 1 : 2) * osr;
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            numErrors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("mismatches %0d, comparisons %0d", numErrors, checked);
        if (numErrors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1;
        @(posedge clock);
        wrStrobe <= 0;
        #1;
    endtask
    task automatic rd(input string name, input logic [3:0] a, input logic [7:0] exp);
        @(posedge clock);
        addr <= a;
        rdStrobe <= 1;
        @(posedge clock);
        rdStrobe <= 0;
        #1;
        check(name, rdData, exp);
    endtask
    // sel 0 waits for a result, sel 1 for a converter clock tick
    task automatic waitFor(input int sel, input int limit, output int cnt);
        logic [19:0] cap;
        cnt = 0;
        do begin
            @(posedge clock);
            cap = filterResult;
            #1;
            cnt++;
        end while ((sel == 0 ? resultReady : converterClockTick) !== 1'b1 && cnt < limit);
        if (cnt >= limit) check("wait limit", cnt, 0);
        if (sel == 0) expRes = cap;
    endtask
    task automatic countResults(input int cycles);
        hits = 0;
        repeat (cycles) begin
            @(posedge clock);
            #1;
            if (resultReady === 1'b1) hits++;
        end
    endtask
    initial begin
        #(40 * 100000);
        numErrors++;
        conclude();
    end
    initial begin
        repeat (3) @(posedge clock);
        rst <= 0;
        rd("ctl0 reset", `ADDR_CTL0, 8'h20);
        rd("ctl1 reset", `ADDR_CTL1, 8'h00);
        rd("clksel reset", `ADDR_CLKSEL, 8'h00);
        check("amp at reset", amplifierPowerEn, 0);
        wr(4'h7, 8'hFF);
        rd("unmapped", 4'h7, 8'h00);
        wr(`ADDR_CTL0, 8'hFF);
        rd("ctl0 mask", `ADDR_CTL0, 8'hFD);
        wr(`ADDR_CTL1, 8'hFF);
        rd("ctl1 mask", `ADDR_CTL1, 8'hFE);
        wr(`ADDR_CLKSEL, 8'hFF);
        rd("clksel mask", `ADDR_CLKSEL, 8'h1F);
        for (int i = 0; i < 8; i++) begin
            wr(`ADDR_CTL0, {i[0], i[1], i[2], 5'h1C});
            check("amp", amplifierPowerEn, !i[2]);
            check("run", converterRunEn, !i[2] && !i[1]);
            check("hold", filterResetHold, !(!i[2] && !i[1] && !i[0]));
        end
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            c0 = (seed[7:0] & 8'h1D) | 8'h20;
            c1 = seed[15:8] & 8'hF8;
            wr(`ADDR_CTL0, c0);
            wr(`ADDR_CTL1, c1);
            check("rate", outputRateSel, c0[4:2]);
            check("chop", chopperTwo, !c1[7]);
            check("latency", lowLatency, c1[7]);
            check("ref", refExternal, c0[0]);
            check("bufs", {refBufNegEn, refBufPosEn}, c1[4:3]);
            rd("ctl1 back", `ADDR_CTL1, c1);
        end
        foreach (periods[k]) begin
            wr(`ADDR_CLKSEL, 8'(k * 3));
            waitFor(1, 100, n);
            waitFor(1, 100, n);
            check("tick gap", n, 2 * (k * 3 + 1));
        end
        // 4.8MHz is out of reach from 25MHz; undivided keeps the runs short
        wr(`ADDR_CLKSEL, 8'h1F);
        wr(`ADDR_IRQ, 8'h03);
        foreach (periods[k]) begin
            wr(`ADDR_CTL1, modes[k]);
            wr(`ADDR_CTL0, 8'h9C);
            wr(`ADDR_CTL0, 8'h1C);
            waitFor(0, 9000, n);
            // one more cycle for the result register after the last count
            check("restart", n, periods[k] + 1);
            waitFor(0, 9000, n);
            check("period", n, periods[k]);
            check("model", n, expPeriod(8'h1C, modes[k]));
            check("result", resultOut, expRes);
            check("irq", irqOut, 1);
        end
        wr(`ADDR_CTL0, 8'h98);
        wr(`ADDR_CTL0, 8'h18);
        waitFor(0, 9000, n);
        waitFor(0, 9000, n);
        check("rate 110", n, expPeriod(8'h18, 8'h80));
        wr(`ADDR_CTL0, 8'h1C);
        rd("ctl1 eoc", `ADDR_CTL1, 8'h82);
        rd("irq reg", `ADDR_IRQ, 8'h07);
        wr(`ADDR_IRQ, 8'h06);
        check("irq masked", irqOut, 0);
        wr(`ADDR_IRQ, 8'h03);
        rd("irq cleared", `ADDR_IRQ, 8'h03);
        wr(`ADDR_CTL1, 8'hC0);
        rd("eoc cleared", `ADDR_CTL1, 8'hC0);
        waitFor(0, 2000, n);
        held = expRes;
        wr(`ADDR_CTL1, 8'hC4);
        // the flag of the result just taken stands until software clears it
        wr(`ADDR_IRQ, 8'h03);
        countResults(2000);
        check("latched hits", hits, 0);
        check("latched value", resultOut, held);
        check("latched irq", irqOut, 0);
        rd("latched eoc", `ADDR_CTL1, 8'hC4);
        rd("latched flag", `ADDR_IRQ, 8'h03);
        rd("byte lo", `ADDR_RES_LO, held[7:0]);
        rd("byte mid", `ADDR_RES_MID, held[15:8]);
        rd("byte hi", `ADDR_RES_HI, {4'h0, held[19:16]});
        wr(`ADDR_CTL1, 8'hC0);
        waitFor(0, 2000, n);
        check("after latch", resultOut, expRes);
        wr(`ADDR_CTL0, 8'h5C);
        countResults(1700);
        check("asleep", hits, 0);
        wr(`ADDR_CTL0, 8'h9C);
        countResults(1700);
        check("held reset", hits, 0);
        wr(`ADDR_CTL0, 8'h3C);
        countResults(1700);
        check("powered off", hits, 0);
        check("amp off", amplifierPowerEn, 0);
        conclude();
    end
endmodule
